// *** inc/i2c_stretch_pkg.sv ***
package i2c_stretch_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] CTL0_OFS = 4'h0;  // bus_control_zero
  localparam logic [3:0] CTL1_OFS = 4'h1;  // bus_control_one
  localparam logic [3:0] STAT_OFS = 4'h2;  // Link state readback

  // Field positions in bus_control_zero
  localparam int UNIT_EN_BIT   = 7;  // bus_unit_enable
  localparam int RELEASE_BIT   = 5;  // stretch_release
  localparam int STOP_IE_BIT   = 4;  // stop_irq_enable
  localparam int POINT_SEL_BIT = 3;  // stretch_point_select

  // Field positions in bus_control_one and status
  localparam int WAKEUP_BIT   = 7;  // address_wakeup_enable
  localparam int STAT_STR_BIT = 0;  // Clock stretch in progress
  localparam int STAT_TX_BIT  = 1;  // transmit_state_flag
  localparam int STAT_AD_BIT  = 2;  // Address byte in progress

  // Reset values
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  // Clock pulse counts within one byte
  localparam logic [3:0] BITS_EARLY = 4'h8;  // Stretch after 8 pulses
  localparam logic [3:0] BITS_LATE  = 4'h9;  // Stretch after 9 pulses
  localparam logic [3:0] BITS_FIRST = 4'h1;  // First pulse of a byte
  localparam logic [3:0] BITS_ZERO  = 4'h0;  // Start seen, no pulse yet
  localparam logic [3:0] BITS_ARMED = 4'hf;  // Await start hold fall
  localparam logic [3:0] BITS_STEP  = 4'h1;  // Counter increment

  // Software control bits of bus_control_zero
  typedef struct packed {
    logic unit_en;               // bus_unit_enable
    logic stretch_release;       // Self-clearing release request
    logic stop_irq_enable;       // Stop interrupt enable
    logic stretch_point_select;  // 0: 8th clock, 1: 9th clock
  } ctl_t;

  // Link state reported to software
  typedef struct packed {
    logic addr_phase;  // Address byte in progress
    logic tx_flag;     // transmit_state_flag
    logic stretching;  // Clock held low
  } link_stat_t;

  // Byte phase of the link side
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,  // No transfer since stop
    PH_ADDR = 2'b01,  // Address byte after start
    PH_DATA = 2'b10   // Data bytes
  } phase_t;

endpackage : i2c_stretch_pkg

// *** sim/i2c_far_end.sv ***
`timescale 1ns/100ps
`default_nettype none
module i2c_far_end (
  input  wire logic link_clk,  // Timing reference for bus edges
  input  wire logic scl_line,  // Resolved clock line level
  output logic      scl_low,   // Pulls the clock line low
  output logic      sda_low    // Pulls the data line low
);
  // Both lines start released to their pull-ups
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // Wait a number of link cycles
  task automatic hold(input int k);
    repeat (k) @(posedge link_clk);
  endtask : hold

  // Wait until the clock line is high; a stretching device holds it low
  task automatic wait_high();
    int n;
    n = 0;
    while (scl_line !== 1'b1 && n < 1000) begin
      @(posedge link_clk);
      n++;
    end
  endtask : wait_high

  // Start: data falls while the clock is high, then one clock fall
  task automatic start();
    wait_high();
    hold(4);
    sda_low <= 1'b1;
    hold(4);
    scl_low <= 1'b1;
    hold(4);
    scl_low <= 1'b0;
  endtask : start

  // Clock pulses; data only moves while the clock is low
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      wait_high();
      hold(4);
      scl_low <= 1'b1;
      hold(4);
      sda_low <= (i % 2 == 0);
      hold(4);
      scl_low <= 1'b0;
    end
  endtask : pulses

  // Stop: data rises while the clock is high
  task automatic stop();
    wait_high();
    hold(4);
    scl_low <= 1'b1;
    hold(4);
    sda_low <= 1'b1;
    hold(4);
    scl_low <= 1'b0;
    wait_high();
    hold(4);
    sda_low <= 1'b0;
    hold(4);
  endtask : stop
endmodule : i2c_far_end
`default_nettype wire

// *** sim/i2c_stretch_release_stop_irq_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module i2c_stretch_release_stop_irq_tb;
  localparam logic [3:0] C0 = i2c_stretch_pkg::CTL0_OFS;  // Control zero
  localparam logic [3:0] C1 = i2c_stretch_pkg::CTL1_OFS;  // Control one
  localparam logic [3:0] C2 = i2c_stretch_pkg::STAT_OFS;  // Status
  localparam logic [7:0] EN  = 8'h01 << i2c_stretch_pkg::UNIT_EN_BIT;
  localparam logic [7:0] REL = 8'h01 << i2c_stretch_pkg::RELEASE_BIT;
  localparam logic [7:0] SIE = 8'h01 << i2c_stretch_pkg::STOP_IE_BIT;
  localparam logic [7:0] SEL = 8'h01 << i2c_stretch_pkg::POINT_SEL_BIT;
  logic        clk, link_clk, arst_n;      // Clocks and reset
  logic [3:0]  reg_addr;                   // Register address
  logic [7:0]  reg_wdata, reg_rdata;       // Register data
  logic        reg_wr, reg_rd, irq;        // Strobes and interrupt
  logic        master_mode, tx_state_set;  // Mode and flag set
  logic        sda_drive_low;              // Shifter wants data low
  logic        scl_out, scl_oe;            // Clock pin drive
  logic        sda_out, sda_oe;            // Data pin drive
  logic        p_scl, p_sda;               // Far end pulls
  logic        rd_q, irq_q;                // Monitor history
  logic [7:0]  exp_q[$];                   // Expected read data
  logic [15:0] lfsr;                       // Random source
  int          n_errors, checks_done;      // Result counters
  int          irq_cnt, irq_exp;           // Interrupt counts
  logic [7:0]  c0_t[3] = '{EN | SIE | SEL, EN | SEL, EN | SIE | SEL};
  logic [7:0]  c1_t[3] = '{8'h00, 8'h00, 8'h80};
  int          irq_t[3] = '{1, 0, 0};
  // Open-drain lines with pull-ups; far clock feeds the generator in master
  wire scl_line = ~(scl_oe | (~master_mode & p_scl));
  wire sda_line = ~(sda_oe | p_sda);
  wire master_scl_low = master_mode & p_scl;

  i2c_stretch_ctl i2c_stretch_ctl_inst (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .master_mode(master_mode),
    .link_clk(link_clk), .master_scl_low(master_scl_low),
    .tx_state_set(tx_state_set), .sda_drive_low(sda_drive_low),
    .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
  i2c_far_end i2c_far_end_inst (
    .link_clk(link_clk), .scl_line(scl_line), .scl_low(p_scl),
    .sda_low(p_sda));

  // System clock, 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Link clock, 32 ns, unrelated phase
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #16 link_clk = ~link_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read; the monitor compares the answer
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : rd

  task automatic lwait(input int k);
    repeat (k) @(posedge link_clk);
    #1;
  endtask : lwait

  // Let the link settle, then check stretch and interrupt count
  task automatic look(input logic [7:0] e);
    lwait(10);
    chk({7'h00, scl_oe}, e);
    chk(irq_cnt[7:0], irq_exp[7:0]);
  endtask : look

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Monitor: read data the cycle after the strobe, interrupt pulses
  always @(posedge clk) begin
    rd_q  <= reg_rd;
    irq_q <= irq;
    if (irq === 1'b1) irq_cnt++;
    if (irq_q === 1'b1) chk({7'h00, irq}, 8'h00);
    if (rd_q === 1'b1) chk(reg_rdata, exp_q.pop_front());
  end

  // Watchdog
  initial begin
    #200000;
    n_errors++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    {arst_n, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {master_mode, tx_state_set, sda_drive_low} = '0;
    {n_errors, checks_done, irq_cnt, irq_exp} = '0;
    lfsr = 16'ha6e1;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    lwait(8);
    // Reset values, unmapped places, random writes and pins, unit off
    rd(C0, 8'h00);
    rd(C1, 8'h00);
    rd(C2, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(C0, lfsr[7:0] & 8'h1f);
      {master_mode, tx_state_set, sda_drive_low} <= lfsr[14:12];
      wr({lfsr[11:10], 2'h3}, lfsr[15:8]);
      rd(C0, lfsr[7:0] & 8'h18);
      rd({lfsr[11:10], 2'h3}, 8'h00);
      wr(C1, lfsr[15:8]);
      rd(C1, lfsr[15:8] & 8'h80);
    end
    {master_mode, tx_state_set, sda_drive_low} <= 3'h0;
    $display("test registers done");
    // Slave address byte stretches at the 9th fall only
    wr(C0, 8'h00);
    wr(C1, 8'h00);
    wr(C0, EN | SIE);
    i2c_far_end_inst.start();
    i2c_far_end_inst.pulses(8);
    look(8'h00);
    i2c_far_end_inst.pulses(1);
    irq_exp++;
    look(8'h01);
    wr(C0, EN | SIE);
    look(8'h01);
    wr(C0, EN | SIE | REL);
    look(8'h00);
    rd(C0, EN | SIE);
    // Data byte, select 0: stretch and interrupt after 8
    i2c_far_end_inst.pulses(8);
    irq_exp++;
    look(8'h01);
    rd(C2, 8'h01);
    wr(C0, EN | SIE | SEL | REL);
    look(8'h00);
    i2c_far_end_inst.pulses(1);
    irq_exp++;
    look(8'h01);
    $display("test select zero done");
    // Transmit flag during the 9th stretch, then release
    @(posedge link_clk);
    tx_state_set  <= 1'b1;
    sda_drive_low <= 1'b1;
    @(posedge link_clk);
    tx_state_set  <= 1'b0;
    lwait(6);
    rd(C2, 8'h03);
    chk({7'h00, sda_oe}, 8'h01);
    wr(C0, EN | SIE | SEL | REL);
    look(8'h00);
    chk({7'h00, sda_oe}, 8'h00);
    rd(C2, 8'h00);
    sda_drive_low <= 1'b0;
    // Select 1: no stretch after 8, stretch after 9
    i2c_far_end_inst.pulses(8);
    look(8'h00);
    i2c_far_end_inst.pulses(1);
    irq_exp++;
    look(8'h01);
    wr(C0, EN | SIE | SEL | REL);
    look(8'h00);
    $display("test select one done");
    // Stop interrupt: enabled, disabled, masked by wakeup
    for (int k = 0; k < 3; k++) begin
      if (k > 0) begin
        wr(C0, 8'h00);
        wr(C1, c1_t[k]);
        wr(C0, c0_t[k]);
        i2c_far_end_inst.start();
      end
      irq_exp += irq_t[k];
      i2c_far_end_inst.stop();
      look(8'h00);
    end
    rd(C1, 8'h80);
    $display("test stop done");
    // Master mode, select 0: own clock held after 8 pulses
    wr(C0, 8'h00);
    wr(C1, 8'h00);
    master_mode <= 1'b1;
    wr(C0, EN | SIE);
    i2c_far_end_inst.start();
    i2c_far_end_inst.pulses(9);
    irq_exp++;
    look(8'h01);
    wr(C0, EN | SIE | REL);
    look(8'h00);
    i2c_far_end_inst.pulses(8);
    irq_exp++;
    look(8'h01);
    wr(C0, EN | SIE | REL);
    look(8'h00);
    i2c_far_end_inst.pulses(1);
    irq_exp++;
    i2c_far_end_inst.stop();
    look(8'h00);
    chk({6'h00, scl_out, sda_out}, 8'h00);
    $display("test master done");
    end_sim();
  end
endmodule : i2c_stretch_release_stop_irq_tb
`default_nettype wire

// *** verilog/i2c_stretch_ctl.sv ***
// Functional notes
// [R1] Writing release ends stretch, bit self-clears
// [R2] Writing zero to release does nothing
// [R3] Release at 9th while transmitting floats data
// [R4] Stop interrupt follows stop enable bit
// [R5] Wakeup enable suppresses the stop interrupt
// [R6] Select 0: transfer interrupt at 8th fall
// [R7] Master, select 0: hold clock after 8
// [R8] Slave, select 0: pull clock after 8
// [R9] Control bits change by write, reset zero
// [R10] Select 1: interrupt and stretch at 9th
// [R11] Address byte always uses the 9th clock
// [R12] Software changes settings only when safe
// [R13] One interrupt pulse per event
`timescale 1ns/100ps
`default_nettype none
module i2c_stretch_ctl (
  input  wire logic       clk,            // System clock, 200 MHz
  input  wire logic       arst_n,         // Async reset, active low
  input  wire logic [3:0] reg_addr,       // Register address
  input  wire logic [7:0] reg_wdata,      // Register write data
  input  wire logic       reg_wr,         // Write strobe
  input  wire logic       reg_rd,         // Read strobe
  output logic      [7:0] reg_rdata,      // Read data, cycle after
  output logic            irq,            // Interrupt request pulse
  input  wire logic       master_mode,    // Unit acts as bus master
  input  wire logic       link_clk,       // Link side clock
  input  wire logic       master_scl_low, // Master clock gen wants low
  input  wire logic       tx_state_set,   // Sets transmit_state_flag
  input  wire logic       sda_drive_low,  // Shifter wants data low
  input  wire logic       scl_in,         // Clock line level
  output logic            scl_out,        // Clock line drive level
  output logic            scl_oe,         // Clock line pulled low
  input  wire logic       sda_in,         // Data line level
  output logic            sda_out,        // Data line drive level
  output logic            sda_oe          // Data line pulled low
);

  // ---------------- System clock domain ----------------
  logic [1:0]                 rst_pipe_reg;  // Reset release chain
  logic                       rst_n;         // Synchronised reset
  i2c_stretch_pkg::ctl_t      ctl_reg;       // bus_control_zero bits
  logic                       wakeup_reg;    // address_wakeup_enable
  logic                       rel_tgl_reg;   // Release request toggle
  logic [2:0]                 ev_s1_reg;     // Event toggles, stage 1
  logic [2:0]                 ev_s2_reg;     // Event toggles, stage 2
  logic [2:0]                 ev_h_reg;      // Event toggle history
  logic [2:0]                 st_s1_reg;     // Status, stage 1
  i2c_stretch_pkg::link_stat_t st_s2_reg;    // Status, stage 2
  logic [7:0]                 rdata_reg;     // Read data
  logic                       irq_reg;       // Interrupt pulse
  logic                       wr0;           // Write to control zero
  logic                       ev_done;       // Release carried out
  logic                       ev_xfer;       // Transfer interrupt event
  logic                       ev_stop;       // Stop condition event
  logic                        lk_done_tgl_reg; // Release done toggle
  logic                        lk_xfer_tgl_reg; // Transfer event toggle
  logic                        lk_stop_tgl_reg; // Stop event toggle
  i2c_stretch_pkg::link_stat_t lk_stat_reg;    // Status to system

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  assign wr0     = reg_wr && (reg_addr == i2c_stretch_pkg::CTL0_OFS);
  assign ev_done = ev_s2_reg[0] ^ ev_h_reg[0];
  assign ev_xfer = ev_s2_reg[1] ^ ev_h_reg[1];
  assign ev_stop = ev_s2_reg[2] ^ ev_h_reg[2];

  // Control register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // [R9] Reset clears bits
      ctl_reg    <= '0;
      wakeup_reg <= 1'b0;
    end else begin
      // [R9] Only writes change
      if (wr0) begin
        ctl_reg.unit_en <= reg_wdata[i2c_stretch_pkg::UNIT_EN_BIT];
        ctl_reg.stop_irq_enable <=
          reg_wdata[i2c_stretch_pkg::STOP_IE_BIT];
        ctl_reg.stretch_point_select <=
          reg_wdata[i2c_stretch_pkg::POINT_SEL_BIT];
      end
      // [R1] Set wins clear
      if (wr0 && reg_wdata[i2c_stretch_pkg::RELEASE_BIT]) begin
        ctl_reg.stretch_release <= 1'b1;
      end else if (ev_done) begin
        ctl_reg.stretch_release <= 1'b0;
      end
      if (reg_wr && (reg_addr == i2c_stretch_pkg::CTL1_OFS)) begin
        wakeup_reg <= reg_wdata[i2c_stretch_pkg::WAKEUP_BIT];
      end
    end
  end

  // Release request crosses to the link as a toggle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rel_tgl_reg <= 1'b0;
    // [R2] Zero is ignored
    end else if (wr0 && reg_wdata[i2c_stretch_pkg::RELEASE_BIT]) begin
      rel_tgl_reg <= ~rel_tgl_reg;
    end
  end

  // Link events and status enter this domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_s1_reg <= 3'h0;
      ev_s2_reg <= 3'h0;
      ev_h_reg  <= 3'h0;
      st_s1_reg <= 3'h0;
      st_s2_reg <= '0;
    end else begin
      ev_s1_reg <= {lk_stop_tgl_reg, lk_xfer_tgl_reg, lk_done_tgl_reg};
      ev_s2_reg <= ev_s1_reg;
      ev_h_reg  <= ev_s2_reg;
      st_s1_reg <= lk_stat_reg;
      st_s2_reg <= st_s1_reg;
    end
  end

  // Interrupt request, one pulse per event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      // [R13] Merge events
      // [R4] Stop gated by enable
      // [R5] Wakeup blocks stop
      irq_reg <= ev_xfer || (ev_stop && ctl_reg.stop_irq_enable &&
                             !wakeup_reg);
    end
  end

  // Register read, data valid in the next cycle only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= i2c_stretch_pkg::READ_ZERO;
    end else begin
      rdata_reg <= i2c_stretch_pkg::READ_ZERO;
      if (reg_rd && reg_addr == i2c_stretch_pkg::CTL0_OFS) begin
        rdata_reg[i2c_stretch_pkg::UNIT_EN_BIT]   <= ctl_reg.unit_en;
        rdata_reg[i2c_stretch_pkg::RELEASE_BIT]   <=
          ctl_reg.stretch_release;
        rdata_reg[i2c_stretch_pkg::STOP_IE_BIT]   <=
          ctl_reg.stop_irq_enable;
        rdata_reg[i2c_stretch_pkg::POINT_SEL_BIT] <=
          ctl_reg.stretch_point_select;
      end else if (reg_rd && reg_addr == i2c_stretch_pkg::CTL1_OFS) begin
        rdata_reg[i2c_stretch_pkg::WAKEUP_BIT] <= wakeup_reg;
      end else if (reg_rd && reg_addr == i2c_stretch_pkg::STAT_OFS) begin
        rdata_reg[i2c_stretch_pkg::STAT_STR_BIT] <= st_s2_reg.stretching;
        rdata_reg[i2c_stretch_pkg::STAT_TX_BIT]  <= st_s2_reg.tx_flag;
        rdata_reg[i2c_stretch_pkg::STAT_AD_BIT]  <= st_s2_reg.addr_phase;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq       = irq_reg;

  // ---------------- Link clock domain ----------------
  logic [1:0]                  lk_rst_reg;     // Link reset chain
  logic                        lrst_n;         // Link reset
  logic [2:0]                  cfg_s1_reg;     // Config, stage 1
  logic [2:0]                  cfg_s2_reg;     // Config: en, sel, mst
  logic [2:0]                  rel_sync_reg;   // Release toggle sync
  logic [2:0]                  scl_sync_reg;   // Clock pin sync
  logic [2:0]                  sda_sync_reg;   // Data pin sync
  i2c_stretch_pkg::phase_t     phase_reg;      // Byte phase
  logic [3:0]                  bitcnt_reg;     // Pulses in this byte
  logic                        stretch_reg;    // Clock held low
  logic                        trc_reg;        // transmit_state_flag
  logic                        scl_oe_reg;     // Clock pull-down
  logic                        sda_oe_reg;     // Data pull-down
  logic                        low_reg;        // Drive level, low
  logic                        l_en;           // Unit enabled
  logic                        l_sel;          // Point select
  logic                        rel_pulse;      // Release request
  logic                        scl_fall;       // Clock falling edge
  logic                        start_det;      // Start condition
  logic                        stop_det;       // Stop condition
  logic [3:0]                  cnt_next;       // Count after a fall
  logic [3:0]                  point;          // Stretch pulse count

  // Link reset release through two flip-flops
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lk_rst_reg <= 2'h0;
    end else begin
      lk_rst_reg <= {lk_rst_reg[0], 1'b1};
    end
  end
  assign lrst_n = lk_rst_reg[1];

  // Synchronisers for config, release and pins
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      cfg_s1_reg   <= 3'h0;
      cfg_s2_reg   <= 3'h0;
      rel_sync_reg <= 3'h0;
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      cfg_s1_reg   <= {ctl_reg.unit_en, ctl_reg.stretch_point_select,
                       master_mode};
      cfg_s2_reg   <= cfg_s1_reg;
      rel_sync_reg <= {rel_sync_reg[1:0], rel_tgl_reg};
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
    end
  end

  assign l_en      = cfg_s2_reg[2];
  assign l_sel     = cfg_s2_reg[1];
  assign rel_pulse = rel_sync_reg[2] ^ rel_sync_reg[1];
  assign scl_fall  = scl_sync_reg[2] && !scl_sync_reg[1];
  assign start_det = scl_sync_reg[1] && scl_sync_reg[2] &&
                     sda_sync_reg[2] && !sda_sync_reg[1];
  assign stop_det  = scl_sync_reg[1] && scl_sync_reg[2] &&
                     !sda_sync_reg[2] && sda_sync_reg[1];
  assign cnt_next  = (bitcnt_reg == i2c_stretch_pkg::BITS_ARMED) ?
                     i2c_stretch_pkg::BITS_ZERO :
                     (bitcnt_reg == i2c_stretch_pkg::BITS_LATE) ?
                     i2c_stretch_pkg::BITS_FIRST :
                     bitcnt_reg + i2c_stretch_pkg::BITS_STEP;
  // [R11] Address uses 9th
  // [R10] Select 1 uses 9th
  assign point = (phase_reg == i2c_stretch_pkg::PH_ADDR || l_sel) ?
                 i2c_stretch_pkg::BITS_LATE : i2c_stretch_pkg::BITS_EARLY;

  // Byte phase and pulse counter
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      phase_reg  <= i2c_stretch_pkg::PH_IDLE;
      bitcnt_reg <= i2c_stretch_pkg::BITS_ARMED;
    end else if (!l_en || stop_det) begin
      phase_reg  <= i2c_stretch_pkg::PH_IDLE;
      bitcnt_reg <= i2c_stretch_pkg::BITS_ARMED;
    end else if (start_det) begin
      phase_reg  <= i2c_stretch_pkg::PH_ADDR;
      bitcnt_reg <= i2c_stretch_pkg::BITS_ARMED;
    end else if (scl_fall) begin
      bitcnt_reg <= cnt_next;
      case (phase_reg)
        // [R11] Setting valid after address
        i2c_stretch_pkg::PH_ADDR: begin
          if (cnt_next == i2c_stretch_pkg::BITS_LATE) begin
            phase_reg <= i2c_stretch_pkg::PH_DATA;
          end
        end
        default: begin
          phase_reg <= phase_reg;
        end
      endcase
    end
  end

  // Stretch hold, released by software or a stop
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      stretch_reg     <= 1'b0;
      lk_xfer_tgl_reg <= 1'b0;
      lk_done_tgl_reg <= 1'b0;
      lk_stop_tgl_reg <= 1'b0;
    end else begin
      if (!l_en || stop_det) begin
        stretch_reg <= 1'b0;
      // [R1] Release ends stretch
      end else if (rel_pulse) begin
        stretch_reg <= 1'b0;
      // [R6] Interrupt at point
      end else if (scl_fall && phase_reg != i2c_stretch_pkg::PH_IDLE &&
                   cnt_next == point) begin
        stretch_reg     <= 1'b1;
        lk_xfer_tgl_reg <= ~lk_xfer_tgl_reg;
      end
      // [R1] Report release done
      if (rel_pulse) begin
        lk_done_tgl_reg <= ~lk_done_tgl_reg;
      end
      if (l_en && stop_det) begin
        lk_stop_tgl_reg <= ~lk_stop_tgl_reg;
      end
    end
  end

  // Transmit state flag
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      trc_reg <= 1'b0;
    end else if (!l_en || stop_det) begin
      trc_reg <= 1'b0;
    // [R3] Release at 9th
    end else if (rel_pulse && stretch_reg && trc_reg &&
                 bitcnt_reg == i2c_stretch_pkg::BITS_LATE) begin
      trc_reg <= 1'b0;
    end else if (tx_state_set) begin
      trc_reg <= 1'b1;
    end
  end

  // Pin drivers and status
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      scl_oe_reg  <= 1'b0;
      sda_oe_reg  <= 1'b0;
      low_reg     <= 1'b0;
      lk_stat_reg <= '0;
    end else begin
      // [R7] Master holds low
      // [R8] Slave pulls low
      scl_oe_reg  <= l_en && (stretch_reg ||
                              (cfg_s2_reg[0] && master_scl_low));
      // [R3] Data floats
      sda_oe_reg  <= l_en && trc_reg && sda_drive_low;
      low_reg     <= 1'b0;
      lk_stat_reg <= {phase_reg == i2c_stretch_pkg::PH_ADDR, trc_reg,
                      stretch_reg};
    end
  end

  assign scl_oe  = scl_oe_reg;
  assign sda_oe  = sda_oe_reg;
  assign scl_out = low_reg;
  assign sda_out = low_reg;

  // ---------------- Assertions ----------------
  sequence s_fall_at(logic [3:0] n);
    l_en && !stop_det && !start_det && !rel_pulse && scl_fall &&
    phase_reg != i2c_stretch_pkg::PH_IDLE && cnt_next == n;
  endsequence
  sequence s_held;
    stretch_reg ##1 scl_oe_reg;
  endsequence

  property p_release_clears;
    @(posedge clk) disable iff (!rst_n)
      $rose(ctl_reg.stretch_release) |-> ##[1:80] !ctl_reg.stretch_release;
  endproperty
  a_release_clears: assert property (p_release_clears) // [R1]
    else $error("release bit did not self-clear");

  property p_zero_write;
    @(posedge clk) disable iff (!rst_n)
      (wr0 && !reg_wdata[i2c_stretch_pkg::RELEASE_BIT]) |=>
        (rel_tgl_reg == $past(rel_tgl_reg));
  endproperty
  a_zero_write: assert property (p_zero_write) // [R2]
    else $error("zero write requested a release");

  property p_stop_irq;
    @(posedge clk) disable iff (!rst_n)
      (ev_stop && ctl_reg.stop_irq_enable && !wakeup_reg) |=> irq;
  endproperty
  a_stop_irq: assert property (p_stop_irq) // [R4]
    else $error("stop interrupt missing");

  property p_wakeup_mask;
    @(posedge clk) disable iff (!rst_n)
      (!ev_xfer && (wakeup_reg || !ctl_reg.stop_irq_enable)) |=> !irq;
  endproperty
  a_wakeup_mask: assert property (p_wakeup_mask) // [R5]
    else $error("masked stop raised interrupt");

  property p_write_only;
    @(posedge clk) disable iff (!rst_n)
      $changed(ctl_reg.stretch_point_select) |-> $past(wr0);
  endproperty
  a_write_only: assert property (p_write_only) // [R9]
    else $error("select bit changed without write");

  property p_irq_cause;
    @(posedge clk) disable iff (!rst_n)
      irq |-> $past(ev_xfer || ev_stop);
  endproperty
  a_irq_cause: assert property (p_irq_cause) // [R13]
    else $error("interrupt without event");

  property p_early;
    @(posedge link_clk) disable iff (!lrst_n)
      (!l_sel && phase_reg == i2c_stretch_pkg::PH_DATA) ##0
        s_fall_at(i2c_stretch_pkg::BITS_EARLY) |=> s_held;
  endproperty
  a_early: assert property (p_early) // [R7]
    else $error("no stretch after 8 pulses");

  property p_late;
    @(posedge link_clk) disable iff (!lrst_n)
      (l_sel || phase_reg == i2c_stretch_pkg::PH_ADDR) ##0
        s_fall_at(i2c_stretch_pkg::BITS_LATE) |=> s_held;
  endproperty
  a_late: assert property (p_late) // [R10]
    else $error("no stretch after 9 pulses");

  property p_float;
    @(posedge link_clk) disable iff (!lrst_n)
      (rel_pulse && stretch_reg && trc_reg &&
       bitcnt_reg == i2c_stretch_pkg::BITS_LATE) |=> !trc_reg ##1 !sda_oe;
  endproperty
  a_float: assert property (p_float) // [R3]
    else $error("data line not floated on release");

endmodule : i2c_stretch_ctl
`default_nettype wire
